// *** inc/flip_pkg.sv ***
package flip_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC    = 20;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned LVL_W      = 2;
  localparam int unsigned NUM_LVL    = 4;
  localparam int unsigned VEC_W      = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned CALL_MCYC  = 4;
  localparam logic [2:0]  CALL_LAST  = 3'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRIO_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h14;

  // Field positions
  localparam int unsigned GLOBAL_EN_BIT  = 31;
  localparam int unsigned EXT0_EDGE_BIT  = 0;
  localparam int unsigned EXT1_EDGE_BIT  = 1;
  localparam int unsigned HWCLR_LSB      = 2;
  localparam int unsigned NUM_HWCLR      = 4;
  localparam int unsigned ST_CALL_BIT    = 4;
  localparam int unsigned ST_VEC_LSB     = 8;

  // Source positions, in arbitration ranking order (rank = index + 1)
  localparam int unsigned SRC_EXT0  = 0;
  localparam int unsigned SRC_TMR0  = 1;
  localparam int unsigned SRC_EXT1  = 2;
  localparam int unsigned SRC_TMR1  = 3;
  localparam int unsigned SRC_TMR2  = 5;
  localparam int unsigned SRC_EXT2  = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CALL_IDLE = 3'h1,
    CALL_REQ  = 3'h2,
    CALL_RUN  = 3'h4
  } flip_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } flip_axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } flip_axi_rsp_type;

  // Fixed vector of each source, by ranking index
  function automatic logic [VEC_W-1:0] vector_of(input logic [4:0] idx);
    case (idx)
      5'h00:   vector_of = 16'h0003;
      5'h01:   vector_of = 16'h000b;
      5'h02:   vector_of = 16'h0013;
      5'h03:   vector_of = 16'h001b;
      5'h04:   vector_of = 16'h0023;
      5'h05:   vector_of = 16'h002b;
      5'h06:   vector_of = 16'h0033;
      5'h07:   vector_of = 16'h003b;
      5'h08:   vector_of = 16'h007b;
      5'h09:   vector_of = 16'h0083;
      5'h0a:   vector_of = 16'h0043;
      5'h0b:   vector_of = 16'h004b;
      5'h0c:   vector_of = 16'h0053;
      5'h0d:   vector_of = 16'h005b;
      5'h0e:   vector_of = 16'h0073;
      5'h0f:   vector_of = 16'h006b;
      5'h10:   vector_of = 16'h008b;
      5'h11:   vector_of = 16'h0093;
      5'h12:   vector_of = 16'h009b;
      5'h13:   vector_of = 16'h0063;
      default: vector_of = 16'h0000;
    endcase
  endfunction : vector_of

endpackage : flip_pkg

// *** logic/flip_resolver.sv ***
`timescale 1ns/10ps
module flip_resolver (
  input  wire logic [19:0] req,
  input  wire logic [19:0] prio_hi,
  input  wire logic [19:0] prio_lo,
  output logic             found,
  output logic [4:0]       idx,
  output logic [1:0]       level
);

  logic [1:0] lvl [20];

  // ----------------------------------------------------------------
  // Level of each source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 20; g++) begin : g_lvl
      assign lvl[g] = {prio_hi[g], prio_lo[g]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Highest level first, lowest ranking index within a level
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    idx   = 5'h00;
    level = 2'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 0; s < 20; s++) begin
        if (!found && req[s] && lvl[s] == 2'(l)) begin
          found = 1'b1;
          idx   = 5'(s);
          level = 2'(l);
        end
      end
    end
  end

endmodule : flip_resolver

// *** logic/flip_controller.sv ***
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module flip_controller (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire flip_pkg::flip_axi_req_type axi_req,
  output flip_pkg::flip_axi_rsp_type      axi_rsp,
  input  wire logic [19:0]                periph_flags,
  input  wire logic                       tmr2_overflow_flag,
  input  wire logic                       tmr2_external_flag,
  input  wire logic                       ext_irq_pin_0,
  input  wire logic                       ext_irq_pin_1,
  input  wire logic                       mc_strobe,
  input  wire logic                       last_cycle,
  input  wire logic                       instr_writes_irq_regs,
  input  wire logic                       instr_is_return_from_interrupt,
  input  wire logic                       call_ack,
  output logic                            call_req_r,
  output logic [15:0]                     call_vector_r,
  output logic [19:0]                     flag_clear_r,
  output logic [3:0]                      in_service_r
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  flip_pkg::flip_axi_rsp_type rsp_r;
  flip_pkg::flip_state_type   state_r;

  logic [19:0] enable_r;
  logic        global_en_r;
  logic [19:0] prio_lo_r;
  logic [19:0] prio_hi_r;
  logic [1:0]  edge_mode_r;
  logic [3:0]  hwclr_sel_r;

  logic        aw_held_r;
  logic [7:0]  aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] en_word, lo_word, hi_word, ctl_word;

  logic [1:0]  pin_meta_r;
  logic [1:0]  pin_sync_r;
  logic [1:0]  pin_prev_r;
  logic [1:0]  ext_flag_r;
  logic [1:0]  ext_flag_nxt;
  logic [1:0]  ext_sw_clr;

  logic [19:0] flags_all;
  logic [19:0] req_live;
  logic        res_found;
  logic [4:0]  res_idx;
  logic [1:0]  res_level;
  logic        svc_any;
  logic [1:0]  svc_level;
  logic        poll_ok;
  logic        return_from_interrupt_done;
  logic        vectoring;
  logic [4:0]  grant_idx_r;
  logic [1:0]  grant_lvl_r;
  logic [2:0]  mcyc_cnt_r;
  logic [3:0]  in_service_nxt;
  logic [19:0] clear_nxt;

  assign axi_rsp = rsp_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == flip_pkg::OFS_ENABLE)  ||
                (a == flip_pkg::OFS_PRIO_LO) ||
                (a == flip_pkg::OFS_PRIO_HI) ||
                (a == flip_pkg::OFS_CTRL)    ||
                (a == flip_pkg::OFS_STATUS)  ||
                (a == flip_pkg::OFS_FLAGS);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  // Both address and data must be held before the write lands, so
  // either arrival order is accepted.
  assign wr_fire = aw_held_r && w_held_r && !rsp_r.bvalid;
  assign wr_ok   = is_mapped(aw_addr_r);
  assign en_word  = merge({global_en_r, 11'h000, enable_r}, w_data_r,
                          w_strb_r);
  assign lo_word  = merge({12'h000, prio_lo_r}, w_data_r, w_strb_r);
  assign hi_word  = merge({12'h000, prio_hi_r}, w_data_r, w_strb_r);
  assign ctl_word = merge({26'h0000000, hwclr_sel_r, edge_mode_r},
                          w_data_r, w_strb_r);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_held_r      <= 1'b0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      rsp_r.awready <= 1'b1;
      rsp_r.wready  <= 1'b1;
      rsp_r.bvalid  <= 1'b0;
      rsp_r.bresp   <= flip_pkg::RESP_OKAY;
    end else begin
      if (axi_req.awvalid && rsp_r.awready) begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= axi_req.awaddr;
        rsp_r.awready <= 1'b0;
      end
      if (axi_req.wvalid && rsp_r.wready) begin
        w_held_r     <= 1'b1;
        w_data_r     <= axi_req.wdata;
        w_strb_r     <= axi_req.wstrb;
        rsp_r.wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        rsp_r.bvalid <= 1'b1;
        rsp_r.bresp  <= wr_ok ? flip_pkg::RESP_OKAY : flip_pkg::RESP_SLVERR;
      end
      if (rsp_r.bvalid && axi_req.bready) begin
        rsp_r.bvalid  <= 1'b0;
        rsp_r.awready <= 1'b1;
        rsp_r.wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r    <= 20'h00000;
      global_en_r <= 1'b0;
      prio_lo_r   <= 20'h00000;
      prio_hi_r   <= 20'h00000;
      edge_mode_r <= 2'h0;
      hwclr_sel_r <= 4'h0;
    end else if (wr_fire) begin
      case (aw_addr_r)
        flip_pkg::OFS_ENABLE: begin
          global_en_r <= en_word[flip_pkg::GLOBAL_EN_BIT];
          enable_r    <= en_word[19:0];
        end
        flip_pkg::OFS_PRIO_LO: begin
          prio_lo_r <= lo_word[19:0];
        end
        flip_pkg::OFS_PRIO_HI: begin
          prio_hi_r <= hi_word[19:0];
        end
        flip_pkg::OFS_CTRL: begin
          {hwclr_sel_r, edge_mode_r} <= ctl_word[5:0];
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_r.arready <= 1'b1;
      rsp_r.rvalid  <= 1'b0;
      rsp_r.rdata   <= 32'h0000_0000;
      rsp_r.rresp   <= flip_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && rsp_r.arready) begin
      rsp_r.arready <= 1'b0;
      rsp_r.rvalid  <= 1'b1;
      rsp_r.rresp   <= is_mapped(axi_req.araddr) ? flip_pkg::RESP_OKAY
                                                 : flip_pkg::RESP_SLVERR;
      case (axi_req.araddr)
        flip_pkg::OFS_ENABLE:  rsp_r.rdata <= {global_en_r, 11'h000,
                                              enable_r};
        flip_pkg::OFS_PRIO_LO: rsp_r.rdata <= {12'h000, prio_lo_r};
        flip_pkg::OFS_PRIO_HI: rsp_r.rdata <= {12'h000, prio_hi_r};
        flip_pkg::OFS_CTRL:    rsp_r.rdata <= {26'h0000000, hwclr_sel_r,
                                              edge_mode_r};
        flip_pkg::OFS_STATUS:  rsp_r.rdata <= {8'h00, call_vector_r,
                                              3'h0, call_req_r,
                                              in_service_r};
        flip_pkg::OFS_FLAGS:   rsp_r.rdata <= {12'h000, flags_all};
        default:               rsp_r.rdata <= 32'h0000_0000;
      endcase
    end else if (rsp_r.rvalid && axi_req.rready) begin
      rsp_r.rvalid  <= 1'b0;
      rsp_r.arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // External pins 0 and 1
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= 2'h3;
      pin_sync_r <= 2'h3;
    end else begin
      pin_meta_r <= {ext_irq_pin_1, ext_irq_pin_0};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Writing one to a flag bit clears an edge-captured flag
  assign ext_sw_clr = (wr_fire && aw_addr_r == flip_pkg::OFS_FLAGS &&
                       w_strb_r[0]) ?
                      {w_data_r[flip_pkg::SRC_EXT1],
                       w_data_r[flip_pkg::SRC_EXT0]} : 2'h0;

  always_comb begin
    ext_flag_nxt = ext_flag_r;
    for (int i = 0; i < 2; i++) begin
      if (!edge_mode_r[i]) begin
        ext_flag_nxt[i] = ~pin_sync_r[i];
      end else if (mc_strobe && pin_prev_r[i] && !pin_sync_r[i]) begin
        ext_flag_nxt[i] = 1'b1; // Set beats any clear
      end else if (ext_sw_clr[i] || clear_nxt[2*i]) begin
        ext_flag_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_r <= 2'h3;
      ext_flag_r <= 2'h0;
    end else begin
      if (mc_strobe) begin
        pin_prev_r <= pin_sync_r;
      end
      ext_flag_r <= ext_flag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Request gathering and resolution
  // ----------------------------------------------------------------
  always_comb begin
    flags_all = periph_flags;
    flags_all[flip_pkg::SRC_EXT0] = ext_flag_r[0];
    flags_all[flip_pkg::SRC_EXT1] = ext_flag_r[1];
    flags_all[flip_pkg::SRC_TMR2] = tmr2_overflow_flag |
                                    tmr2_external_flag;
  end

  // Live flags only: nothing denied is kept for a later poll
  assign req_live = flags_all & enable_r & {20{global_en_r}};

  flip_resolver u_resolver (
    .req     (req_live),
    .prio_hi (prio_hi_r),
    .prio_lo (prio_lo_r),
    .found   (res_found),
    .idx     (res_idx),
    .level   (res_level)
  );

  always_comb begin
    svc_any   = |in_service_r;
    svc_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_r[l]) begin
        svc_level = 2'(l);
      end
    end
  end

  // No level can exceed svc_level 3, so level 3 is never preempted
  assign poll_ok = (state_r == flip_pkg::CALL_IDLE) && mc_strobe &&
                   res_found &&
                   (!svc_any || res_level > svc_level) &&
                   last_cycle &&
                   !instr_writes_irq_regs && !instr_is_return_from_interrupt;

  assign return_from_interrupt_done = mc_strobe && last_cycle && instr_is_return_from_interrupt;
  assign vectoring = (state_r == flip_pkg::CALL_REQ) && call_ack;

  // ----------------------------------------------------------------
  // Call sequence
  // ----------------------------------------------------------------
  // The sequencer pushes only the program counter, as a plain call
  // does; status word saving stays with the service routine.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r       <= flip_pkg::CALL_IDLE;
      call_req_r    <= 1'b0;
      call_vector_r <= 16'h0000;
      grant_idx_r   <= 5'h00;
      grant_lvl_r   <= 2'h0;
      mcyc_cnt_r    <= 3'h0;
    end else begin
      case (state_r)
        flip_pkg::CALL_IDLE: begin
          if (poll_ok) begin
            state_r       <= flip_pkg::CALL_REQ;
            call_req_r    <= 1'b1;
            call_vector_r <= flip_pkg::vector_of(res_idx);
            grant_idx_r   <= res_idx;
            grant_lvl_r   <= res_level;
          end
        end
        flip_pkg::CALL_REQ: begin
          if (call_ack) begin
            state_r    <= flip_pkg::CALL_RUN;
            call_req_r <= 1'b0;
            mcyc_cnt_r <= 3'h0;
          end
        end
        flip_pkg::CALL_RUN: begin
          // No poll until the call's machine cycles are spent
          if (mc_strobe) begin
            if (mcyc_cnt_r == flip_pkg::CALL_LAST) begin
              state_r <= flip_pkg::CALL_IDLE;
            end else begin
              mcyc_cnt_r <= mcyc_cnt_r + 3'h1;
            end
          end
        end
        default: begin
          state_r    <= flip_pkg::CALL_IDLE;
          call_req_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // In-service record
  // ----------------------------------------------------------------
  always_comb begin
    in_service_nxt = in_service_r;
    if (return_from_interrupt_done && svc_any) begin
      in_service_nxt[svc_level] = 1'b0;
    end
    if (vectoring) begin
      in_service_nxt[grant_lvl_r] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_service_r <= 4'h0;
    end else begin
      in_service_r <= in_service_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Hardware flag clearing on vectoring
  // ----------------------------------------------------------------
  always_comb begin
    clear_nxt = 20'h00000;
    if (vectoring) begin
      case (grant_idx_r)
        5'(flip_pkg::SRC_TMR0),
        5'(flip_pkg::SRC_TMR1): clear_nxt[grant_idx_r] = 1'b1;
        5'(flip_pkg::SRC_EXT0): clear_nxt[grant_idx_r] = edge_mode_r[0];
        5'(flip_pkg::SRC_EXT1): clear_nxt[grant_idx_r] = edge_mode_r[1];
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (grant_idx_r == 5'(flip_pkg::SRC_EXT2 + k)) begin
              clear_nxt[grant_idx_r] = hwclr_sel_r[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_clear_r <= 20'h00000;
    end else begin
      flag_clear_r <= clear_nxt;
    end
  end

endmodule : flip_controller

// *** sim/flip_monitor.sv ***
`timescale 1ns/10ps
module flip_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        mc_strobe,
  input wire logic        last_cycle,
  input wire logic        instr_writes_irq_regs,
  input wire logic        instr_is_return_from_interrupt,
  input wire logic        call_ack,
  input wire logic        call_req_r,
  input wire logic [15:0] call_vector_r,
  input wire logic [19:0] flag_clear_r,
  input wire logic [3:0]  in_service_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_req_held: assert property (
    call_req_r && !call_ack |=> call_req_r && $stable(call_vector_r))
    else $error("call request not held");
  a_ack_drop: assert property (
    call_req_r && call_ack |=> !call_req_r) else $error("call after ack");
  a_call_gate: assert property (
    !(mc_strobe && last_cycle && !instr_writes_irq_regs && !instr_is_return_from_interrupt)
    && !call_req_r |=> !call_req_r) else $error("ungated call");
  a_top_block: assert property (
    in_service_r[3] && !call_req_r |=> !call_req_r)
    else $error("call over top level");
  a_svc_set: assert property (
    call_req_r && call_ack |=> in_service_r > $past(in_service_r))
    else $error("in service not raised");
  a_clr_pulse: assert property (
    flag_clear_r != 20'h0 |=> flag_clear_r == 20'h0)
    else $error("clear pulse too long");
  a_clr_kept: assert property (
    flag_clear_r[9:4] == 6'h0 && flag_clear_r[19:14] == 6'h0)
    else $error("software flag cleared");
  a_call_gap: assert property (
    $fell(call_req_r) |-> !call_req_r [*8]) else $error("call too soon");
endmodule : flip_monitor

bind flip_controller flip_monitor mon (.clk, .reset_n, .mc_strobe,
  .last_cycle, .instr_writes_irq_regs, .instr_is_return_from_interrupt, .call_ack,
  .call_req_r, .call_vector_r, .flag_clear_r, .in_service_r);

// *** sim/flip_core_model.sv ***
`timescale 1ns/10ps
module flip_core_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       call_req_r,
  input  wire logic [3:0] ack_delay,
  output logic            mc_strobe,
  output logic            call_ack
);
  logic [1:0] phase_r;
  logic [3:0] wait_r;
  // Machine cycle of four clocks, strobe on the last
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign mc_strobe = (phase_r == 2'h3);
  // Ack after a chosen delay, so slow sequencers are covered too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r   <= 4'h0;
      call_ack <= 1'b0;
    end else begin
      call_ack <= call_req_r && !call_ack && wait_r == ack_delay;
      wait_r   <= (call_req_r && !call_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : flip_core_model

// *** sim/four_level_interrupt_priority_tb.sv ***
`timescale 1ns/10ps
module four_level_interrupt_priority_tb;
  logic                       clk = 1'b0;
  logic                       reset_n = 1'b0;
  flip_pkg::flip_axi_req_type axi_req = '0;
  flip_pkg::flip_axi_rsp_type axi_rsp;
  logic [19:0]                periph_flags = '0;
  logic [19:0]                flag_clear_r, clr_seen, en, hi, lo, f;
  logic [15:0]                call_vector_r;
  logic [3:0]                 in_service_r, ack_delay = '0;
  logic                       ext_irq_pin_0 = 1'b1, last_cycle = 1'b1;
  logic                       ext_irq_pin_1 = 1'b1;
  logic                       t2o = 1'b0, t2x = 1'b0;
  logic                       instr_writes_irq_regs = 1'b0;
  logic                       instr_is_return_from_interrupt = 1'b0;
  logic                       mc_strobe, call_ack, call_req_r;
  logic [31:0]                seed = 32'h6e87, r, d;
  int                         n_errors = 0, samples_checked = 0;
  logic [15:0] vtab [20] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h007b, 16'h0083, 16'h0043,
    16'h004b, 16'h0053, 16'h005b, 16'h0073, 16'h006b, 16'h008b, 16'h0093,
    16'h009b, 16'h0063};
  flip_controller dut (.clk, .reset_n, .axi_req, .axi_rsp, .periph_flags,
    .tmr2_overflow_flag(t2o), .tmr2_external_flag(t2x), .ext_irq_pin_0,
    .ext_irq_pin_1, .mc_strobe, .last_cycle, .instr_writes_irq_regs,
    .instr_is_return_from_interrupt, .call_ack, .call_req_r, .call_vector_r, .flag_clear_r,
    .in_service_r);
  flip_core_model core (.clk, .reset_n, .call_req_r, .ack_delay,
    .mc_strobe, .call_ack);
  always #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Returns {level, vector}; scanning down makes low rank win ties
  function automatic logic [17:0] pick(input logic [19:0] f, g, h, l);
    logic [2:0] best;
    best = 3'h0;
    pick = '0;
    for (int i = 19; i >= 0; i--) begin
      if (f[i] && g[i] && {1'b1, h[i], l[i]} >= best) begin
        best = {1'b1, h[i], l[i]};
        pick = {h[i], l[i], vtab[i]};
      end
    end
  endfunction : pick
  task automatic chk(input string n, input logic [31:0] x, g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] rs);
    @(posedge clk);
    axi_req.awaddr  <= a;
    axi_req.wdata   <= v;
    axi_req.wstrb   <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    fork
      begin
        @(posedge clk iff axi_rsp.awready);
        axi_req.awvalid <= 1'b0;
      end
      begin
        @(posedge clk iff axi_rsp.wready);
        axi_req.wvalid <= 1'b0;
      end
    join
    @(posedge clk iff axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    chk("bresp", rs, axi_rsp.bresp);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] rs);
    @(posedge clk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    @(posedge clk iff axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    @(posedge clk iff axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
    d = axi_rsp.rdata;
    chk("rresp", rs, axi_rsp.rresp);
  endtask : axr
  task automatic grant(input logic [17:0] x);
    int n;
    n = 0;
    while (call_req_r !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("vector", x[15:0], call_vector_r);
    @(posedge clk iff call_ack);
    repeat (3) begin
      @(posedge clk);
      clr_seen |= flag_clear_r;
    end
    chk("level", 1, in_service_r[x[17:16]]);
  endtask : grant
  task automatic quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge clk);
      s |= call_req_r;
    end
    chk("no call", 0, s);
  endtask : quiet
  task automatic retire();
    @(posedge clk);
    instr_is_return_from_interrupt <= 1'b1;
    @(posedge clk iff mc_strobe);
    instr_is_return_from_interrupt <= 1'b0;
  endtask : retire
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1_000_000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    axr(flip_pkg::OFS_STATUS, flip_pkg::RESP_OKAY);
    chk("status", 0, d);
    axr(8'h40, flip_pkg::RESP_SLVERR);
    axw(8'h44, 32'hffffffff, flip_pkg::RESP_SLVERR);
    repeat (30) begin
      r = rnd();
      axw(flip_pkg::OFS_ENABLE, r, flip_pkg::RESP_OKAY);
      en = r[19:0] & {20{r[31]}};
      r = rnd();
      axw(flip_pkg::OFS_PRIO_LO, r, flip_pkg::RESP_OKAY);
      lo = r[19:0];
      r = rnd();
      axw(flip_pkg::OFS_PRIO_HI, r, flip_pkg::RESP_OKAY);
      hi = r[19:0];
      axr(flip_pkg::OFS_PRIO_HI, flip_pkg::RESP_OKAY);
      chk("prio hi", {12'h000, hi}, d);
      r = rnd();
      ack_delay <= r[23:20];
      f = r[19:0] & 20'hffffa;
      f[5] = r[5] | r[24];
      {t2x, t2o} <= {r[24], r[5]};
      periph_flags <= f;
      if (pick(f, en, hi, lo) != 18'h0) begin
        grant(pick(f, en, hi, lo));
      end else begin
        quiet(12);
      end
      periph_flags <= '0;
      {t2x, t2o} <= 2'h0;
      quiet(20);
      retire();
      quiet(2);
      chk("idle", 0, in_service_r);
    end
    axw(flip_pkg::OFS_ENABLE, 32'h8000001a, flip_pkg::RESP_OKAY);
    axw(flip_pkg::OFS_PRIO_LO, 32'h0000000a, flip_pkg::RESP_OKAY);
    axw(flip_pkg::OFS_PRIO_HI, 32'h00000010, flip_pkg::RESP_OKAY);
    clr_seen = '0;
    periph_flags <= 20'h00008;
    grant({2'h1, 16'h001b});
    periph_flags <= 20'h0000a;
    quiet(40);
    periph_flags <= 20'h0001a;
    grant({2'h2, 16'h0023});
    chk("nested", 4'h6, in_service_r);
    chk("cleared", 20'h00008, clr_seen);
    periph_flags <= 20'h00002;
    retire();
    retire();
    instr_writes_irq_regs <= 1'b1;
    quiet(40);
    instr_writes_irq_regs <= 1'b0;
    last_cycle <= 1'b0;
    quiet(40);
    periph_flags <= '0;
    last_cycle <= 1'b1;
    quiet(20);
    axw(flip_pkg::OFS_ENABLE, 32'h80000003, flip_pkg::RESP_OKAY);
    axw(flip_pkg::OFS_PRIO_LO, 32'h00000003, flip_pkg::RESP_OKAY);
    axw(flip_pkg::OFS_PRIO_HI, 32'h00000003, flip_pkg::RESP_OKAY);
    clr_seen = '0;
    ext_irq_pin_0 <= 1'b0;
    grant({2'h3, 16'h0003});
    periph_flags <= 20'h00002;
    quiet(40);
    chk("level kept", 0, clr_seen);
    ext_irq_pin_0 <= 1'b1;
    periph_flags <= '0;
    retire();
    axw(flip_pkg::OFS_CTRL, 32'h00000002, flip_pkg::RESP_OKAY);
    axw(flip_pkg::OFS_ENABLE, 32'h80000004, flip_pkg::RESP_OKAY);
    clr_seen = '0;
    ext_irq_pin_1 <= 1'b0;
    grant({2'h0, 16'h0013});
    chk("edge clear", 20'h00004, clr_seen);
    axr(flip_pkg::OFS_FLAGS, flip_pkg::RESP_OKAY);
    chk("flags", 0, d);
    finish_test();
  end
endmodule : four_level_interrupt_priority_tb
